/* common/lsa_pkg.sv */
package lsa_pkg;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_PROX_OPT = 8'h0c;
    localparam logic [7:0] OFF_IR_SEL   = 8'h0e;
    localparam logic [7:0] OFF_AUX_SEL  = 8'h0f;
    localparam logic [7:0] OFF_VIS_REC  = 8'h10;
    localparam logic [7:0] OFF_VIS_GAIN = 8'h11;
    localparam logic [7:0] OFF_STATUS   = 8'h14;

    // -------------------------------------------------------------------
    // reset values and writable bits
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_PROX_OPT  = 8'h04;
    localparam logic [7:0] RST_IR_SEL    = 8'h00;
    localparam logic [7:0] RST_AUX_SEL   = 8'h65;
    localparam logic [7:0] RST_VIS_REC   = 8'h70;
    localparam logic [7:0] RST_VIS_GAIN  = 8'h00;
    localparam logic [7:0] MASK_PROX_OPT = 8'h24;
    localparam logic [7:0] MASK_VIS_REC  = 8'h70;
    localparam logic [7:0] MASK_VIS_GAIN = 8'h07;

    // -------------------------------------------------------------------
    // field positions and input select codes
    // -------------------------------------------------------------------
    localparam int         PROX_RANGE_BIT = 5;
    localparam int         PROX_MODE_BIT  = 2;
    localparam int         VIS_REC_LSB    = 4;
    localparam int         VIS_REC_MSB    = 6;
    localparam int         VIS_GAIN_MSB   = 2;
    localparam logic [7:0] IR_SEL_SMALL   = 8'h00;
    localparam logic [7:0] IR_SEL_LARGE   = 8'h03;
    localparam logic [7:0] AUX_SEL_TEMP   = 8'h65;
    localparam logic [7:0] AUX_SEL_VDD    = 8'h75;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int ADC_CLK_PERIOD_NS   = 50;
    localparam int CORE_CLK_PERIOD_NS  = 10;
    localparam int ADC_CLK_CORE_CYCLES =
        (ADC_CLK_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LSA_KIND_VIS  = 2'b00,
        LSA_KIND_IR   = 2'b01,
        LSA_KIND_AUX  = 2'b10,
        LSA_KIND_PROX = 2'b11
    } lsa_kind_t;

    typedef enum logic [1:0] {
        LSA_ST_IDLE    = 2'b00,
        LSA_ST_RECOVER = 2'b01,
        LSA_ST_INTEG   = 2'b10
    } lsa_state_t;

    // recovery code to adc clocks: 1, 7, 15, 31 ... 511
    function automatic logic [9:0] rec_adc_clocks(input logic [2:0] code);
        logic [10:0] pow;
        pow = 11'h004 << code;
        if (code == 3'h0) begin
            rec_adc_clocks = 10'h001;
        end else begin
            rec_adc_clocks = 10'(pow - 11'h001);
        end
    endfunction : rec_adc_clocks

endpackage : lsa_pkg

/* design/lsa_adc_input_cfg.sv */
// Notes on behaviour
// [RQ1] range bit set selects high range, gain/14.5
// [RQ2] mode bit clear means raw adc conversions
// [RQ3] ir select 0x00 small, 0x03 large photodiode
// [RQ4] aux 0x65 temperature, 0x75 supply, ground referenced
// [RQ5] host treats temperature as relative only
// [RQ6] visible recovery 1..511 adc clocks times 2^gain
// [RQ7] host programs recovery as complement of gain
// [RQ8] options byte resets to 0x04
// [RQ9] aux select resets to 0x65
// [RQ10] visible recovery byte resets to 0x70
// [RQ11] early silicon: visible recovery also governs ir
// [RQ12] visible integration lengthened by 2^gain, max 128
//
// Decided for this implementation: the address-and-strobe port.
module lsa_adc_input_cfg
    import lsa_pkg::*;
#(
    parameter bit         EARLY_SILICON    = 1'b1,
    parameter int         ADC_CLK_CYCLES   = ADC_CLK_CORE_CYCLES,
    parameter int         INTEG_ADC_CLOCKS = 16,
    parameter logic [7:0] VIS_MUX_CODE     = 8'h00
)
(
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    output logic      [7:0] rd_data_out,
    input  wire logic       meas_req_in,
    input  wire logic [1:0] meas_kind_in,
    input  wire logic [7:0] prox_mux_in,
    input  wire logic [2:0] ir_rec_code_in,
    input  wire logic [2:0] ir_gain_in,
    output logic      [7:0] adc_mux_out,
    output logic            adc_ref_gnd_out,
    output logic            adc_sample_out,
    output logic      [2:0] gain_shift_out,
    output logic            prox_high_range_out,
    output logic            prox_raw_mode_out,
    output logic            busy_out,
    output logic            meas_done_out
);

    // -------------------------------------------------------------------
    // register file
    // -------------------------------------------------------------------
    logic [7:0]  prox_opt_w;
    logic [7:0]  ir_sel_w;
    logic [7:0]  aux_sel_w;
    logic [7:0]  vis_rec_w;
    logic [7:0]  vis_gain_w;
    logic [7:0]  status_w;
    lsa_state_t  state_r;
    lsa_kind_t   kind_r;
    logic [19:0] cnt_r;
    logic [19:0] integ_r;

    assign status_w = {5'h00, busy_out, kind_r};

    lsa_cfg_regs u_regs (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_en_in),
        .rd_en_in     (rd_en_in),
        .addr_in      (addr_in),
        .wr_data_in   (wr_data_in),
        .status_in    (status_w),
        .prox_opt_out (prox_opt_w),
        .ir_sel_out   (ir_sel_w),
        .aux_sel_out  (aux_sel_w),
        .vis_rec_out  (vis_rec_w),
        .vis_gain_out (vis_gain_w),
        .rd_data_out  (rd_data_out)
    );

    // -------------------------------------------------------------------
    // cycle arithmetic
    // -------------------------------------------------------------------
    // adc clocks to core cycles, scaled by 2^shift; 20 bits hold 511*5*128
    function automatic logic [19:0] scale_cycles(input logic [9:0] adc_clks,
                                                 input logic [2:0] shift);
        logic [19:0] base;
        base = 20'(adc_clks) * 20'(ADC_CLK_CYCLES);
        scale_cycles = base << shift;
    endfunction : scale_cycles

    logic [2:0]  vis_rec_code_w;
    logic [2:0]  vis_gain_code_w;
    logic [19:0] vis_rec_cycles_w;
    logic [19:0] ir_rec_cycles_w;
    logic [19:0] vis_integ_w;
    logic [19:0] plain_integ_w;
    logic        accept_w;

    assign vis_rec_code_w  = vis_rec_w[VIS_REC_MSB:VIS_REC_LSB];
    assign vis_gain_code_w = vis_gain_w[VIS_GAIN_MSB:0];
    // recovery stretched by the visible gain code
    assign vis_rec_cycles_w = scale_cycles(rec_adc_clocks(vis_rec_code_w),
                                           vis_gain_code_w);          // RQ6
    // older parts have no separate ir recovery; the visible one rules
    assign ir_rec_cycles_w = EARLY_SILICON ? vis_rec_cycles_w         // RQ11
        : scale_cycles(rec_adc_clocks(ir_rec_code_in), ir_gain_in);
    assign vis_integ_w   = scale_cycles(10'(INTEG_ADC_CLOCKS),
                                        vis_gain_code_w);             // RQ12
    assign plain_integ_w = scale_cycles(10'(INTEG_ADC_CLOCKS), 3'h0);
    // requests while busy are dropped, the sequencer must wait for done
    assign accept_w = meas_req_in && (state_r == LSA_ST_IDLE);

    // -------------------------------------------------------------------
    // measurement sequencer
    // -------------------------------------------------------------------
    // settings are latched at acceptance so a write mid-run cannot tear
    // the recovery or integration length
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= LSA_ST_IDLE;
            kind_r  <= LSA_KIND_VIS;
            cnt_r   <= 20'h00000;
            integ_r <= 20'h00000;
        end else begin
            case (state_r)
                LSA_ST_IDLE: begin
                    if (accept_w) begin
                        kind_r <= lsa_kind_t'(meas_kind_in);
                        case (lsa_kind_t'(meas_kind_in))
                            LSA_KIND_VIS: begin
                                state_r <= LSA_ST_RECOVER;
                                cnt_r   <= vis_rec_cycles_w - 20'h1; // RQ6
                                integ_r <= vis_integ_w;             // RQ12
                            end
                            LSA_KIND_IR: begin
                                state_r <= LSA_ST_RECOVER;
                                cnt_r   <= ir_rec_cycles_w - 20'h1; // RQ11
                                integ_r <= plain_integ_w;
                            end
                            default: begin
                                state_r <= LSA_ST_INTEG;
                                cnt_r   <= plain_integ_w - 20'h1;
                                integ_r <= plain_integ_w;
                            end
                        endcase
                    end
                end
                LSA_ST_RECOVER: begin
                    if (cnt_r == 20'h00000) begin
                        state_r <= LSA_ST_INTEG;
                        cnt_r   <= integ_r - 20'h1;
                    end else begin
                        cnt_r <= cnt_r - 20'h1;
                    end
                end
                LSA_ST_INTEG: begin
                    if (cnt_r == 20'h00000) begin
                        state_r <= LSA_ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 20'h1;
                    end
                end
                default: state_r <= LSA_ST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // adc input routing
    // -------------------------------------------------------------------
    // mux code is held for the whole run, set at acceptance
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            adc_mux_out     <= 8'h00;
            adc_ref_gnd_out <= 1'b0;
            gain_shift_out  <= 3'h0;
        end else if (accept_w) begin
            adc_ref_gnd_out <= 1'b0;
            gain_shift_out  <= 3'h0;
            case (lsa_kind_t'(meas_kind_in))
                LSA_KIND_VIS: begin
                    adc_mux_out    <= VIS_MUX_CODE;
                    gain_shift_out <= vis_gain_code_w;              // RQ12
                end
                LSA_KIND_IR:  adc_mux_out <= ir_sel_w;              // RQ3
                LSA_KIND_AUX: begin
                    adc_mux_out     <= aux_sel_w;                   // RQ4
                    adc_ref_gnd_out <= 1'b1;                        // RQ4
                end
                default:      adc_mux_out <= prox_mux_in;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // status outputs
    // -------------------------------------------------------------------
    // done is a single pulse on the last integration cycle's edge
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            busy_out       <= 1'b0;
            adc_sample_out <= 1'b0;
            meas_done_out  <= 1'b0;
        end else begin
            busy_out       <= accept_w ||
                              (state_r == LSA_ST_RECOVER) ||
                              (state_r == LSA_ST_INTEG &&
                               cnt_r != 20'h00000);
            adc_sample_out <= (accept_w && meas_kind_in[1]) ||
                              (state_r == LSA_ST_RECOVER &&
                               cnt_r == 20'h00000) ||
                              (state_r == LSA_ST_INTEG &&
                               cnt_r != 20'h00000);
            meas_done_out  <= (state_r == LSA_ST_INTEG) &&
                              (cnt_r == 20'h00000);
        end
    end

    // -------------------------------------------------------------------
    // proximity converter options
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prox_high_range_out <= 1'b0;
            prox_raw_mode_out   <= 1'b0;
        end else begin
            prox_high_range_out <= prox_opt_w[PROX_RANGE_BIT];      // RQ1
            prox_raw_mode_out   <= !prox_opt_w[PROX_MODE_BIT];      // RQ2
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    logic first_r;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    property p_range;
        @(posedge core_clk_in) disable iff (reset_in)
        ##1 prox_high_range_out == $past(prox_opt_w[PROX_RANGE_BIT]);
    endproperty
    a_range: assert property (p_range) // RQ1
        else $error("high range flag does not follow option bit");

    property p_raw_mode;
        @(posedge core_clk_in) disable iff (reset_in)
        $changed(prox_opt_w[PROX_MODE_BIT]) |=>
            prox_raw_mode_out != $past(prox_opt_w[PROX_MODE_BIT]);
    endproperty
    a_raw_mode: assert property (p_raw_mode) // RQ2
        else $error("raw mode flag is not the inverse of mode bit");

    property p_ir_route;
        @(posedge core_clk_in) disable iff (reset_in)
        accept_w && meas_kind_in == LSA_KIND_IR |=>
            adc_mux_out == $past(ir_sel_w) && !adc_ref_gnd_out
            throughout (busy_out [*2]);
    endproperty
    a_ir_route: assert property (p_ir_route) // RQ3
        else $error("ir measurement routed wrong input");

    property p_aux_route;
        @(posedge core_clk_in) disable iff (reset_in)
        accept_w && meas_kind_in == LSA_KIND_AUX |=>
            adc_mux_out == $past(aux_sel_w) && adc_ref_gnd_out;
    endproperty
    a_aux_route: assert property (p_aux_route) // RQ4
        else $error("aux measurement not routed to ground reference");

    property p_vis_recover;
        @(posedge core_clk_in) disable iff (reset_in)
        accept_w && meas_kind_in == LSA_KIND_VIS |=>
            state_r == LSA_ST_RECOVER &&
            cnt_r == $past(vis_rec_cycles_w) - 20'h1;
    endproperty
    a_vis_recover: assert property (p_vis_recover) // RQ6
        else $error("visible recovery length wrong");

    property p_recover_end;
        @(posedge core_clk_in) disable iff (reset_in)
        state_r == LSA_ST_RECOVER && cnt_r == 20'h00000 |=>
            state_r == LSA_ST_INTEG && adc_sample_out ##1 busy_out;
    endproperty
    a_recover_end: assert property (p_recover_end) // RQ6
        else $error("integration did not follow recovery");

    property p_opt_reset;
        @(posedge core_clk_in) disable iff (reset_in)
        first_r |-> prox_opt_w == RST_PROX_OPT;
    endproperty
    a_opt_reset: assert property (p_opt_reset) // RQ8
        else $error("options byte reset value wrong");

    property p_aux_reset;
        @(posedge core_clk_in) disable iff (reset_in)
        first_r |-> aux_sel_w == RST_AUX_SEL;
    endproperty
    a_aux_reset: assert property (p_aux_reset) // RQ9
        else $error("aux select reset value wrong");

    property p_rec_reset;
        @(posedge core_clk_in) disable iff (reset_in)
        first_r |-> vis_rec_w == RST_VIS_REC;
    endproperty
    a_rec_reset: assert property (p_rec_reset) // RQ10
        else $error("visible recovery reset value wrong");

    property p_ir_early;
        @(posedge core_clk_in) disable iff (reset_in)
        accept_w && meas_kind_in == LSA_KIND_IR && EARLY_SILICON |=>
            cnt_r == $past(vis_rec_cycles_w) - 20'h1;
    endproperty
    a_ir_early: assert property (p_ir_early) // RQ11
        else $error("ir recovery ignores visible setting on early part");

    property p_vis_integ;
        @(posedge core_clk_in) disable iff (reset_in)
        accept_w && meas_kind_in == LSA_KIND_VIS |=>
            integ_r == $past(vis_integ_w) &&
            gain_shift_out == $past(vis_gain_code_w);
    endproperty
    a_vis_integ: assert property (p_vis_integ) // RQ12
        else $error("visible integration not scaled by gain");

    property p_done_pulse;
        @(posedge core_clk_in) disable iff (reset_in)
        meas_done_out |-> !busy_out ##1 !meas_done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done is not a single pulse");

endmodule : lsa_adc_input_cfg

/* design/lsa_cfg_regs.sv */
// configuration register store; read data come out of a flop
module lsa_cfg_regs
    import lsa_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] status_in,
    output logic      [7:0] prox_opt_out,
    output logic      [7:0] ir_sel_out,
    output logic      [7:0] aux_sel_out,
    output logic      [7:0] vis_rec_out,
    output logic      [7:0] vis_gain_out,
    output logic      [7:0] rd_data_out
);

    // -------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------
    // reserved bits are masked at write so they always read zero
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prox_opt_out <= RST_PROX_OPT;                   // RQ8
            ir_sel_out   <= RST_IR_SEL;
            aux_sel_out  <= RST_AUX_SEL;                    // RQ9
            vis_rec_out  <= RST_VIS_REC;                    // RQ10
            vis_gain_out <= RST_VIS_GAIN;
        end else if (wr_en_in) begin
            case (addr_in)
                OFF_PROX_OPT: prox_opt_out <= wr_data_in & MASK_PROX_OPT;
                OFF_IR_SEL:   ir_sel_out   <= wr_data_in;
                OFF_AUX_SEL:  aux_sel_out  <= wr_data_in;
                OFF_VIS_REC:  vis_rec_out  <= wr_data_in & MASK_VIS_REC;
                OFF_VIS_GAIN: vis_gain_out <= wr_data_in & MASK_VIS_GAIN;
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------
    // data stand one cycle only; unmapped offsets read zero
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            case (addr_in)
                OFF_PROX_OPT: rd_data_out <= prox_opt_out;
                OFF_IR_SEL:   rd_data_out <= ir_sel_out;
                OFF_AUX_SEL:  rd_data_out <= aux_sel_out;
                OFF_VIS_REC:  rd_data_out <= vis_rec_out;
                OFF_VIS_GAIN: rd_data_out <= vis_gain_out;
                OFF_STATUS:   rd_data_out <= status_in;
                default:      rd_data_out <= 8'h00;
            endcase
        end else begin
            rd_data_out <= 8'h00;
        end
    end

endmodule : lsa_cfg_regs

/* dv/lsa_adc_input_cfg_tb_top.sv */
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module lsa_adc_input_cfg_tb_top
    import lsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // one core clock per adc clock keeps the long recovery counts short
    localparam int AC = 1;
    // mux code that visible runs must route; handed to the design too
    localparam logic [7:0] VIS_MUX_CODE = 8'h00;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] rdata;
    logic       req = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [7:0] pmux = 8'h00;
    logic [2:0] irc = 3'h0;
    logic [2:0] irg = 3'h0;
    logic [7:0] mux;
    logic       refg;
    logic       samp;
    logic [2:0] gsh;
    logic       hi;
    logic       raw;
    logic       busy;
    logic       done;
    int         num_errors = 0;
    int         n_tests = 0;
    logic [31:0] seed = 32'he4f5a515;
    logic [7:0] regm [logic [7:0]];
    logic [7:0] alist [6] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};

    lsa_adc_input_cfg #(
        .ADC_CLK_CYCLES(AC),
        .VIS_MUX_CODE(VIS_MUX_CODE)
    ) dut (
        .core_clk_in(clk), .reset_in(rst), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rdata), .meas_req_in(req), .meas_kind_in(kind),
        .prox_mux_in(pmux), .ir_rec_code_in(irc), .ir_gain_in(irg),
        .adc_mux_out(mux), .adc_ref_gnd_out(refg), .adc_sample_out(samp),
        .gain_shift_out(gsh), .prox_high_range_out(hi),
        .prox_raw_mode_out(raw), .busy_out(busy), .meas_done_out(done)
    );

    always #5 clk = ~clk;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    // writable bits per offset; unmapped offsets keep nothing
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h0c:        return 8'h24;
            8'h0e, 8'h0f: return 8'hff;
            8'h10:        return 8'h70;
            8'h11:        return 8'h07;
            default:      return 8'h00;
        endcase
    endfunction : msk

    function automatic int rc(input int code);
        return (code == 0) ? 1 : (1 << (code + 2)) - 1;
    endfunction : rc

    // every step assigns each bus signal once, so ops run back to back
    task automatic bus(input logic w, r, input logic [7:0] a, d);
        wr_en <= w;
        rd_en <= r;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, 1'b0, a, d);
        regm[a] = d & msk(a);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        `CHK("rd_data", regm[a], rdata)
        bus(1'b0, 1'b0, a, 8'h00);
    endtask : rd

    // request, poke a dropped request mid-run, count cycles to done
    // integration lasts 16 adc clocks scaled by the expected gain shift
    task automatic run(input logic [1:0] k, input int en,
                       input logic [7:0] em, input logic er,
                       input logic [2:0] eg);
        int n;
        int ns;
        n = 0;
        ns = 0;
        req  <= 1'b1;
        kind <= k;
        @(posedge clk);
        #1;
        req <= 1'b0;
        if (samp === 1'b1) ns++;
        while (done !== 1'b1 && n < 80000) begin
            @(posedge clk);
            #1;
            n++;
            if (samp === 1'b1) ns++;
            if (n == 1) begin
                `CHK("mux", em, mux)
                `CHK("ref_gnd", er, refg)
                `CHK("gain", eg, gsh)
                `CHK("busy", 1'b1, busy)
            end
            if (n == 3) req <= 1'b1;
            if (n == 4) req <= 1'b0;
        end
        `CHK("cycles", en, n)
        `CHK("sample", (16 * AC) << eg, ns)
        @(posedge clk);
        #1;
        `CHK("busy_after", 1'b0, busy)
        $display("test kind %0d done in %0d cycles", k, n);
    endtask : run

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // ---------------------------------------------------------------
    // watchdog: whole run is a few thousand cycles
    // ---------------------------------------------------------------
    initial begin
        #(20000 * 10);
        num_errors++;
        end_of_test();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0] a;
        regm[8'h0c] = 8'h04;
        regm[8'h0d] = 8'h00;
        regm[8'h0e] = 8'h00;
        regm[8'h0f] = 8'h65;
        regm[8'h10] = 8'h70;
        regm[8'h11] = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        rst <= 1'b0;
        foreach (alist[i]) rd(alist[i]);
        `CHK("raw_reset", 1'b0, raw)
        for (int i = 0; i < 18; i++) begin
            a = alist[i % 6];
            wr(a, 8'(rnd()));
            rd(a);
        end
        $display("test registers done");
        for (int v = 0; v < 4; v++) begin
            wr(8'h0c, {2'b00, v[1], 2'b00, v[0], 2'b00});
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            `CHK("high_range", v[1], hi)
            `CHK("raw_mode", !v[0], raw)
        end
        $display("test options done");
        wr(8'h11, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, 8'(c << 4));
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            run(LSA_KIND_VIS, rc(c) * AC + 16 * AC, VIS_MUX_CODE,
                1'b0, 3'h0);
        end
        // host style: recovery code is the complement of the gain code
        wr(8'h10, 8'h40);
        wr(8'h11, 8'h03);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run(LSA_KIND_VIS, (63 + 16) * AC * 8, VIS_MUX_CODE,
            1'b0, 3'h3);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h07);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run(LSA_KIND_VIS, 17 * AC * 128, VIS_MUX_CODE,
            1'b0, 3'h7);
        // ir recovery follows the visible code, not the ir input
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h20);
        wr(8'h0e, IR_SEL_LARGE);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        irc <= 3'h5 | 3'(rnd());
        run(LSA_KIND_IR, (15 + 16) * AC, IR_SEL_LARGE, 1'b0,
            3'h0);
        wr(8'h0e, IR_SEL_SMALL);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run(LSA_KIND_IR, (15 + 16) * AC, IR_SEL_SMALL, 1'b0,
            3'h0);
        wr(8'h0f, AUX_SEL_VDD);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        run(LSA_KIND_AUX, 16 * AC, AUX_SEL_VDD, 1'b1, 3'h0);
        wr(8'h0f, AUX_SEL_TEMP);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        // temperature is routed only; its value is relative, never checked
        run(LSA_KIND_AUX, 16 * AC, AUX_SEL_TEMP, 1'b1, 3'h0);
        pmux <= 8'(rnd());
        @(posedge clk);
        #1;
        run(LSA_KIND_PROX, 16 * AC, pmux, 1'b0, 3'h0);
        // status: idle, last kind proximity
        regm[8'h14] = 8'h03;
        rd(8'h14);
        end_of_test();
    end

endmodule : lsa_adc_input_cfg_tb_top
